// *** rtl/svto_consts.vh ***
// Purpose: Constants for the servo velocity/torque object block
// Assumes: 40 MHz clock, register index is the bus address
// Notes:   Times for window and threshold qualification are in ms
`ifndef SVTO_CONSTS_VH
`define SVTO_CONSTS_VH

// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define SVTO_A_ENC_SPEED    16'h6069
`define SVTO_A_SPD_DEMAND   16'h606B
`define SVTO_A_MOT_SPEED    16'h606C
`define SVTO_A_COIN_WIDTH   16'h606D
`define SVTO_A_COIN_TIME    16'h606E
`define SVTO_A_THR_LEVEL    16'h606F
`define SVTO_A_THR_TIME     16'h6070
`define SVTO_A_TRQ_CMD      16'h6071
`define SVTO_A_TRQ_CEIL     16'h6072
`define SVTO_A_TRQ_DEMAND   16'h6074
`define SVTO_A_TRQ_READING  16'h6077
`define SVTO_A_RAMP_RATE    16'h6087
`define SVTO_A_SPD_FF       16'h60B1
`define SVTO_A_TRQ_FF       16'h60B2
`define SVTO_A_FWD_LIMIT    16'h60E0
`define SVTO_A_REV_LIMIT    16'h60E1
`define SVTO_A_SPD_CMD      16'h60FF
`define SVTO_A_MODE         16'h7000
`define SVTO_A_STATUS_WORD  16'h7001
`define SVTO_A_IRQ_STATUS   16'h7002
`define SVTO_A_IRQ_ENABLE   16'h7003
`define SVTO_A_IRQ_CLEAR    16'h7004

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SVTO_RST_CEIL       16'h0BB8
`define SVTO_RST_RAMP       32'h0000_0064
`define SVTO_RST_LIMIT      16'hFFFF

// ----------------------------------------------------------------
// Modes of operation
// ----------------------------------------------------------------
`define SVTO_MODE_PT        3'h0
`define SVTO_MODE_PV        3'h1
`define SVTO_MODE_CSP       3'h2
`define SVTO_MODE_CSV       3'h3
`define SVTO_MODE_CST       3'h4

// ----------------------------------------------------------------
// Status bits and timing
// ----------------------------------------------------------------
`define SVTO_SW_COIN_BIT    10
`define SVTO_SW_THR_BIT     12
`define SVTO_IRQ_COIN_BIT   0
`define SVTO_IRQ_THR_BIT    1
`define SVTO_CLK_HZ         40000000
`define SVTO_MS_PER_S       1000
`define SVTO_SLOPE_DIV      1000
`define SVTO_TRQ_MAX_POS    17'sh0_7FFF
`define SVTO_TRQ_MIN_NEG    17'sh1_8000

`endif

// *** rtl/svto_qualifier.v ***
// Purpose: Holds a condition for a programmed count of ms ticks
// Assumes: ms_tick_i is a one-cycle enable
// Notes:   A zero time qualifies on the first cycle the condition holds
`timescale 1ns/1ps
`default_nettype none
module svto_qualifier (
  input  wire        clock_i,
  input  wire        sys_rst_i,
  input  wire        ms_tick_i,
  input  wire        cond_i,
  input  wire [15:0] time_ms_i,
  output reg         qualified_o
);
  reg [15:0] elapsed;

  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      elapsed     <= 16'h0000;
      qualified_o <= 1'b0;
    end else if (!cond_i) begin
      // Any break in the condition restarts the wait
      elapsed     <= 16'h0000;
      qualified_o <= 1'b0;
    end else begin
      if (ms_tick_i && elapsed != 16'hFFFF) begin
        elapsed <= elapsed + 16'h0001;
      end
      qualified_o <= (elapsed >= time_ms_i);
    end
  end
endmodule
`default_nettype wire

// *** rtl/svto_core.v ***
// Purpose: Velocity and torque reference, monitor and limit objects
// Assumes: Measured speeds and the loop demand arrive on this clock
// Notes:   Register index equals bus address; reads answer next cycle
`timescale 1ns/1ps
`default_nettype none
`include "svto_consts.vh"
module svto_core (
  input  wire        clock_i,
  input  wire        sys_rst_i,
  input  wire [15:0] addr_i,
  input  wire [31:0] wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [31:0] rdata_o,
  input  wire [31:0] enc_speed_i,
  input  wire [31:0] motor_speed_i,
  input  wire [31:0] traj_speed_i,
  input  wire [31:0] pos_ctrl_speed_i,
  output reg  [31:0] speed_ref_o,
  output reg  [15:0] torque_ref_o,
  output reg  [15:0] torque_ff_o,
  output reg  [15:0] status_word_o,
  output wire        irq_o
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function [15:0] min_u16;
    input [15:0] a;
    input [15:0] b;
    begin
      min_u16 = (a < b) ? a : b;
    end
  endfunction

  function [17:0] sx18;
    input [15:0] v;
    begin
      sx18 = {{2{v[15]}}, v};
    end
  endfunction

  function [16:0] sat17;
    input signed [17:0] v;
    input signed [16:0] hi;
    input signed [16:0] lo;
    begin
      if (v > hi) begin
        sat17 = hi;
      end else if (v < lo) begin
        sat17 = lo;
      end else begin
        sat17 = v[16:0];
      end
    end
  endfunction

  localparam integer MS_CYCLES = `SVTO_CLK_HZ / `SVTO_MS_PER_S;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [15:0] coin_width;
  reg [15:0] coin_time;
  reg [15:0] thr_level;
  reg [15:0] thr_time;
  reg [15:0] trq_cmd;
  reg [15:0] trq_ceil;
  reg [31:0] ramp_rate;
  reg [31:0] spd_ff;
  reg [15:0] trq_ff;
  reg [15:0] fwd_limit;
  reg [15:0] rev_limit;
  reg [31:0] spd_cmd;
  reg [2:0]  mode;
  reg [1:0]  irq_status;
  reg [1:0]  irq_enable;

  // Input samples from the measurement logic, torque demand and ramp state on this clock
  reg [31:0] enc_speed;
  reg [31:0] motor_speed;
  reg [31:0] speed_demand;
  reg [15:0] trq_demand;
  reg [15:0] trq_ramp;
  reg [31:0] slope_acc;

  // ----------------------------------------------------------------
  // Timebase: 1 ms tick and 1/1000 s slope tick
  // ----------------------------------------------------------------
  reg [15:0] ms_cnt;
  reg        ms_tick;
  // Free-running: the first counted ms of a wait may be short
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      ms_cnt  <= 16'h0000;
      ms_tick <= 1'b0;
    end else if (ms_cnt == MS_CYCLES[15:0] - 16'h0001) begin
      ms_cnt  <= 16'h0000;
      ms_tick <= 1'b1;
    end else begin
      ms_cnt  <= ms_cnt + 16'h0001;
      ms_tick <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Speed monitoring
  // ----------------------------------------------------------------
  // One extra bit so the difference of two extremes cannot wrap
  wire signed [32:0] spd_diff = $signed({spd_cmd[31], spd_cmd})
                              - $signed({motor_speed[31], motor_speed});
  wire        [32:0] spd_abs  = spd_diff[32] ? (33'h0_0000_0000 - spd_diff) : spd_diff;
  wire coin_cond = (spd_abs <= {17'h0_0000, coin_width});
  wire thr_cond  = ($signed(motor_speed) > $signed({16'h0000, thr_level}));
  wire coin_ok;
  wire thr_ok;

  svto_qualifier u_coin (
    .clock_i     (clock_i),
    .sys_rst_i   (sys_rst_i),
    .ms_tick_i   (ms_tick),
    .cond_i      (coin_cond),
    .time_ms_i   (coin_time),
    .qualified_o (coin_ok)
  );

  svto_qualifier u_thr (
    .clock_i     (clock_i),
    .sys_rst_i   (sys_rst_i),
    .ms_tick_i   (ms_tick),
    .cond_i      (thr_cond),
    .time_ms_i   (thr_time),
    .qualified_o (thr_ok)
  );

  // ----------------------------------------------------------------
  // Torque limits and reference
  // ----------------------------------------------------------------
  wire [15:0] pos_lim = min_u16(trq_ceil, fwd_limit);
  wire [15:0] neg_lim = min_u16(trq_ceil, rev_limit);
  // Clip to the signed range so negating a limit cannot wrap
  wire signed [16:0] hi_lim = (pos_lim > 16'h7FFF) ? `SVTO_TRQ_MAX_POS
                                                   : $signed({1'b0, pos_lim});
  wire signed [16:0] lo_lim = (neg_lim > 16'h8000) ? `SVTO_TRQ_MIN_NEG
                                                   : -$signed({1'b0, neg_lim});
  wire is_pt  = (mode == `SVTO_MODE_PT);
  wire is_cst = (mode == `SVTO_MODE_CST);
  wire is_csp = (mode == `SVTO_MODE_CSP);
  wire is_csv = (mode == `SVTO_MODE_CSV);
  wire is_pv  = (mode == `SVTO_MODE_PV);

  reg  signed [17:0] trq_sum;
  reg         [16:0] trq_sat;
  always @* begin
    trq_sum = sx18(trq_cmd);
    if (is_pt) begin
      trq_sum = sx18(trq_ramp);
    end else if (is_cst) begin
      trq_sum = $signed(sx18(trq_cmd)) + $signed(sx18(trq_ff));
    end
    trq_sat = sat17(trq_sum, hi_lim, lo_lim);
  end

  // Ramp moves one step per ms by slope/1000 accumulated per second
  wire signed [16:0] ramp_s   = $signed({trq_ramp[15], trq_ramp});
  wire signed [16:0] target_s = $signed({trq_cmd[15], trq_cmd});
  // Spare top bit keeps a near-maximum slope from wrapping
  wire [32:0] next_acc = {1'b0, slope_acc} + {1'b0, ramp_rate};
  wire [32:0] step_q   = next_acc / `SVTO_SLOPE_DIV;
  wire [16:0] step     = (step_q > 33'h0_0000_FFFF) ? 17'h0_FFFF : step_q[16:0];
  wire signed [17:0] up_v = $signed({ramp_s[16], ramp_s}) + $signed({1'b0, step});
  wire signed [17:0] dn_v = $signed({ramp_s[16], ramp_s}) - $signed({1'b0, step});

  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      trq_ramp  <= 16'h0000;
      slope_acc <= 32'h0000_0000;
    end else if (!is_pt) begin
      // Start a later profile ramp from the torque now output
      trq_ramp  <= trq_demand;
      slope_acc <= 32'h0000_0000;
    end else if (ms_tick) begin
      slope_acc <= next_acc[31:0] - step_q[31:0] * `SVTO_SLOPE_DIV;
      if (ramp_s < target_s) begin
        trq_ramp <= (up_v > target_s) ? trq_cmd : up_v[15:0];
      end else if (ramp_s > target_s) begin
        trq_ramp <= (dn_v < target_s) ? trq_cmd : dn_v[15:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs and sampled values
  // ----------------------------------------------------------------
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      enc_speed     <= 32'h0000_0000;
      motor_speed   <= 32'h0000_0000;
      speed_demand  <= 32'h0000_0000;
      trq_demand    <= 16'h0000;
      speed_ref_o   <= 32'h0000_0000;
      torque_ref_o  <= 16'h0000;
      torque_ff_o   <= 16'h0000;
      status_word_o <= 16'h0000;
    end else begin
      enc_speed   <= enc_speed_i;
      motor_speed <= motor_speed_i;
      // Position loop feeds the speed loop only in cyclic position mode
      speed_demand <= is_csp ? pos_ctrl_speed_i : traj_speed_i;
      trq_demand   <= trq_sat[15:0];
      torque_ref_o <= trq_sat[15:0];
      torque_ff_o  <= (is_csp || is_csv) ? trq_ff : 16'h0000;
      if (is_csp) begin
        speed_ref_o <= spd_ff;
      end else if (is_pv || is_csv) begin
        speed_ref_o <= spd_cmd;
      end else begin
        speed_ref_o <= 32'h0000_0000;
      end
      // Only the two qualified bits are owned here
      status_word_o <= 16'h0000;
      status_word_o[`SVTO_SW_COIN_BIT] <= coin_ok;
      status_word_o[`SVTO_SW_THR_BIT]  <= thr_ok;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts: rising status bits are sticky, set beats clear
  // ----------------------------------------------------------------
  reg coin_q;
  reg thr_q;
  wire [1:0] irq_set = {thr_ok & ~thr_q, coin_ok & ~coin_q};
  wire       clr_wr  = wr_i && addr_i == `SVTO_A_IRQ_CLEAR;
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      coin_q     <= 1'b0;
      thr_q      <= 1'b0;
      irq_status <= 2'b00;
    end else begin
      coin_q     <= coin_ok;
      thr_q      <= thr_ok;
      irq_status <= (irq_status & ~(clr_wr ? wdata_i[1:0] : 2'b00)) | irq_set;
    end
  end
  assign irq_o = |(irq_status & irq_enable);

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      coin_width <= 16'h0000;
      coin_time  <= 16'h0000;
      thr_level  <= 16'h0000;
      thr_time   <= 16'h0000;
      trq_cmd    <= 16'h0000;
      trq_ceil   <= `SVTO_RST_CEIL;
      ramp_rate  <= `SVTO_RST_RAMP;
      spd_ff     <= 32'h0000_0000;
      trq_ff     <= 16'h0000;
      fwd_limit  <= `SVTO_RST_LIMIT;
      rev_limit  <= `SVTO_RST_LIMIT;
      spd_cmd    <= 32'h0000_0000;
      mode       <= `SVTO_MODE_PT;
      irq_enable <= 2'b00;
    end else if (wr_i) begin
      // Read-only and unmapped indices are ignored
      case (addr_i)
        `SVTO_A_COIN_WIDTH: coin_width <= wdata_i[15:0];
        `SVTO_A_COIN_TIME:  coin_time  <= wdata_i[15:0];
        `SVTO_A_THR_LEVEL:  thr_level  <= wdata_i[15:0];
        `SVTO_A_THR_TIME:   thr_time   <= wdata_i[15:0];
        `SVTO_A_TRQ_CMD:    trq_cmd    <= wdata_i[15:0];
        `SVTO_A_TRQ_CEIL:   trq_ceil   <= wdata_i[15:0];
        `SVTO_A_RAMP_RATE:  ramp_rate  <= wdata_i;
        `SVTO_A_SPD_FF:     spd_ff     <= wdata_i;
        `SVTO_A_TRQ_FF:     trq_ff     <= wdata_i[15:0];
        `SVTO_A_FWD_LIMIT:  fwd_limit  <= wdata_i[15:0];
        `SVTO_A_REV_LIMIT:  rev_limit  <= wdata_i[15:0];
        `SVTO_A_SPD_CMD:    spd_cmd    <= wdata_i;
        `SVTO_A_MODE:       mode       <= wdata_i[2:0];
        `SVTO_A_IRQ_ENABLE: irq_enable <= wdata_i[1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register reads, data valid the cycle after the strobe
  // ----------------------------------------------------------------
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (rd_i) begin
      case (addr_i)
        `SVTO_A_ENC_SPEED:   rdata_o <= enc_speed;
        `SVTO_A_SPD_DEMAND:  rdata_o <= speed_demand;
        `SVTO_A_MOT_SPEED:   rdata_o <= motor_speed;
        `SVTO_A_COIN_WIDTH:  rdata_o <= {16'h0000, coin_width};
        `SVTO_A_COIN_TIME:   rdata_o <= {16'h0000, coin_time};
        `SVTO_A_THR_LEVEL:   rdata_o <= {16'h0000, thr_level};
        `SVTO_A_THR_TIME:    rdata_o <= {16'h0000, thr_time};
        `SVTO_A_TRQ_CMD:     rdata_o <= {16'h0000, trq_cmd};
        `SVTO_A_TRQ_CEIL:    rdata_o <= {16'h0000, trq_ceil};
        `SVTO_A_TRQ_DEMAND:  rdata_o <= {16'h0000, trq_demand};
        `SVTO_A_TRQ_READING: rdata_o <= {16'h0000, trq_demand};
        `SVTO_A_RAMP_RATE:   rdata_o <= ramp_rate;
        `SVTO_A_SPD_FF:      rdata_o <= spd_ff;
        `SVTO_A_TRQ_FF:      rdata_o <= {16'h0000, trq_ff};
        `SVTO_A_FWD_LIMIT:   rdata_o <= {16'h0000, fwd_limit};
        `SVTO_A_REV_LIMIT:   rdata_o <= {16'h0000, rev_limit};
        `SVTO_A_SPD_CMD:     rdata_o <= spd_cmd;
        `SVTO_A_MODE:        rdata_o <= {29'h0000_0000, mode};
        `SVTO_A_STATUS_WORD: rdata_o <= {16'h0000, status_word_o};
        `SVTO_A_IRQ_STATUS:  rdata_o <= {30'h0000_0000, irq_status};
        `SVTO_A_IRQ_ENABLE:  rdata_o <= {30'h0000_0000, irq_enable};
        // The clear register is write-only and reads as zero
        default:             rdata_o <= 32'h0000_0000;
      endcase
    end else begin
      rdata_o <= 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

// *** testbench/svto_tb_funcs.svh ***
// Purpose: Expected torque after the limit stage
// Assumes: Included inside a module body
// Notes:   Limits above the signed 16-bit range clip to that range
function automatic logic [15:0] svto_sat(input logic signed [17:0] v, input logic [15:0] cl,
                                         input logic [15:0] fw, input logic [15:0] rv);
  logic signed [17:0] hi;
  logic signed [17:0] lo;
  logic signed [17:0] r;
  hi = $signed({2'b00, (cl < fw) ? cl : fw});
  lo = -$signed({2'b00, (cl < rv) ? cl : rv});
  if (hi > 18'sh0_7FFF)
    hi = 18'sh0_7FFF;
  if (lo < 18'sh3_8000)
    lo = 18'sh3_8000;
  r = (v > hi) ? hi : ((v < lo) ? lo : v);
  return r[15:0];
endfunction

// *** testbench/svto_host_model.sv ***
// Purpose: Host controller side of the object register port
// Assumes: Single clock, slave never stalls
// Notes:   Idle address is inverted, and data too after a write, so stale values never match
`timescale 1ns/1ps
`default_nettype none
module svto_host_model (
  input  wire logic        clock_i,
  input  wire logic [31:0] rdata_i,
  output var  logic [15:0] addr_o,
  output var  logic [31:0] wdata_o,
  output var  logic        wr_o,
  output var  logic        rd_o
);
  initial begin
    addr_o  = 16'h0000;
    wdata_o = 32'h0000_0000;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
  end
  task automatic bus_wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge clock_i);
    wr_o    <= 1'b0;
    addr_o  <= ~a;
    wdata_o <= ~d;
  endtask
  task automatic bus_rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge clock_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge clock_i);
    rd_o   <= 1'b0;
    addr_o <= ~a;
    @(posedge clock_i);
    d = rdata_i;
  endtask
endmodule
`default_nettype wire

// *** testbench/svto_properties.sv ***
// Purpose: Port-level properties of the velocity/torque object block
// Assumes: Settings are mirrored by snooping register writes
// Notes:   Only zero qualification times are timed; ms windows are not checked here or in the bench
`timescale 1ns/1ps
`default_nettype none
`include "svto_consts.vh"
module svto_properties (
  input wire        clock_i,
  input wire        sys_rst_i,
  input wire [15:0] addr_i,
  input wire [31:0] wdata_i,
  input wire        wr_i,
  input wire        rd_i,
  input wire [31:0] rdata_o,
  input wire [31:0] enc_speed_i,
  input wire [31:0] motor_speed_i,
  input wire [31:0] traj_speed_i,
  input wire [31:0] pos_ctrl_speed_i,
  input wire [31:0] speed_ref_o,
  input wire [15:0] torque_ref_o,
  input wire [15:0] torque_ff_o,
  input wire [15:0] status_word_o,
  input wire        irq_o
);
  `include "svto_tb_funcs.svh"
  logic [15:0] wid, ctm, lvl, ttm, cl, fw, rv, tgt, ofs;
  logic [31:0] cmd, sff;
  logic [2:0]  mode;
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      {wid, ctm, lvl, ttm, tgt, ofs, cmd, sff, mode} <= '0;
      cl <= `SVTO_RST_CEIL;
      fw <= `SVTO_RST_LIMIT;
      rv <= `SVTO_RST_LIMIT;
    end else if (wr_i) begin
      case (addr_i)
        `SVTO_A_COIN_WIDTH: wid <= wdata_i[15:0];
        `SVTO_A_COIN_TIME:  ctm <= wdata_i[15:0];
        `SVTO_A_THR_LEVEL:  lvl <= wdata_i[15:0];
        `SVTO_A_THR_TIME:   ttm <= wdata_i[15:0];
        `SVTO_A_TRQ_CMD:    tgt <= wdata_i[15:0];
        `SVTO_A_TRQ_FF:     ofs <= wdata_i[15:0];
        `SVTO_A_TRQ_CEIL:   cl  <= wdata_i[15:0];
        `SVTO_A_FWD_LIMIT:  fw  <= wdata_i[15:0];
        `SVTO_A_REV_LIMIT:  rv  <= wdata_i[15:0];
        `SVTO_A_SPD_CMD:    cmd <= wdata_i;
        `SVTO_A_SPD_FF:     sff <= wdata_i;
        `SVTO_A_MODE:       mode <= wdata_i[2:0];
        default: ;
      endcase
    end
  end
  wire [32:0] diff = {cmd[31], cmd} - {motor_speed_i[31], motor_speed_i};
  wire [32:0] adif = diff[32] ? -diff : diff;
  wire        coin = adif <= {17'h0_0000, wid};
  wire        thr  = $signed(motor_speed_i) > $signed({16'h0000, lvl});
  wire [17:0] tin  = (mode == `SVTO_MODE_CST) ? {{2{tgt[15]}}, tgt} + {{2{ofs[15]}}, ofs}
                                              : {{2{tgt[15]}}, tgt};
  wire [15:0] etq  = svto_sat(tin, cl, fw, rv);
  wire [15:0] btq  = svto_sat({{2{torque_ref_o[15]}}, torque_ref_o}, cl, fw, rv);
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  // Two quiet cycles let a written setting reach the outputs
  sequence s_quiet; !wr_i [*2]; endsequence
  sequence s_coin_in; (coin && ctm == 16'h0000) [*6]; endsequence
  sequence s_coin_out; (!coin) [*6]; endsequence
  sequence s_thr_in; (thr && ttm == 16'h0000) [*6]; endsequence
  sequence s_thr_out; (!thr) [*6]; endsequence
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  chk_read_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0000_0000)
    else $error("read data present without a read");
  chk_demand_read: assert property (rd_i && addr_i == `SVTO_A_TRQ_DEMAND |=>
    rdata_o == {16'h0000, $past(torque_ref_o)}) else $error("torque demand read wrong");
  chk_coin_set: assert property (s_coin_in |-> status_word_o[10])
    else $error("coincidence bit not set");
  chk_coin_clear: assert property (s_coin_out |-> !status_word_o[10])
    else $error("coincidence bit set outside width");
  chk_thr_set: assert property (s_thr_in |-> status_word_o[12])
    else $error("threshold bit not set");
  chk_thr_clear: assert property (s_thr_out |-> !status_word_o[12])
    else $error("threshold bit set at or below level");
  chk_torque_select: assert property (s_quiet |-> mode == `SVTO_MODE_PT ||
    torque_ref_o == etq) else $error("torque reference wrong for mode");
  chk_torque_bounds: assert property (s_quiet |-> btq == torque_ref_o)
    else $error("torque reference outside limits");
  chk_ff_select: assert property (s_quiet |-> torque_ff_o == ((mode == `SVTO_MODE_CSP ||
    mode == `SVTO_MODE_CSV) ? ofs : 16'h0000)) else $error("torque feedforward wrong");
  chk_speed_select: assert property (s_quiet |-> speed_ref_o ==
    ((mode == `SVTO_MODE_CSP) ? sff : (mode == `SVTO_MODE_PV || mode == `SVTO_MODE_CSV)
    ? cmd : 32'h0000_0000)) else $error("speed reference wrong for mode");
endmodule
bind svto_core svto_properties u_props (.clock_i, .sys_rst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
  .rdata_o, .enc_speed_i, .motor_speed_i, .traj_speed_i, .pos_ctrl_speed_i, .speed_ref_o,
  .torque_ref_o, .torque_ff_o, .status_word_o, .irq_o);
`default_nettype wire

// *** testbench/tb_top.sv ***
// Purpose: Self-checking bench for the velocity/torque object block
// Assumes: Host model drives the register port
// Notes:   Profile torque ramp is seen only as reaching the ceiling
`timescale 1ns/1ps
`default_nettype none
`include "svto_consts.vh"
module tb_top;
  `include "svto_tb_funcs.svh"
  logic        clock_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [31:0] enc = 32'h0, motor = 32'h0, traj = 32'h0, pos = 32'h0;
  wire  [15:0] addr;
  wire  [31:0] wdata, rdata, speed_ref;
  wire         wr, rd, irq;
  wire  [15:0] torque_ref, torque_ff, status_word;
  int          miscompares = 0, n_compared = 0, cycles = 0, i, k;
  integer      seed = 32'hab18_70d5;
  logic [15:0] tgt, ofs, cl, fw, rv, ex;
  logic [31:0] ff, cmd;
  logic [2:0]  md;
  logic [17:0] sum;
  always #12.5 clock_i = ~clock_i;
  svto_host_model host (.clock_i(clock_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
                        .wr_o(wr), .rd_o(rd));
  svto_core uut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .enc_speed_i(enc), .motor_speed_i(motor),
    .traj_speed_i(traj), .pos_ctrl_speed_i(pos), .speed_ref_o(speed_ref),
    .torque_ref_o(torque_ref), .torque_ff_o(torque_ff), .status_word_o(status_word),
    .irq_o(irq));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [31:0] e);
    logic [31:0] d;
    host.bus_rd(a, d);
    check(d, e);
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  task automatic wrap_up;
    $display("Compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Ceiling covers reset, register checks and at most one ms tick
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 70000) begin
      miscompares = miscompares + 1;
      wrap_up();
    end
  end
  initial begin
    wait_n(5);
    sys_rst_i <= 1'b0;
    rd_chk(`SVTO_A_TRQ_CEIL, 32'h0000_0BB8);
    rd_chk(`SVTO_A_RAMP_RATE, 32'h0000_0064);
    rd_chk(`SVTO_A_SPD_FF, 32'h0000_0000);
    rd_chk(`SVTO_A_COIN_WIDTH, 32'h0000_0000);
    rd_chk(16'h1234, 32'h0000_0000);
    host.bus_wr(`SVTO_A_TRQ_DEMAND, 32'h0000_1234);
    rd_chk(`SVTO_A_TRQ_DEMAND, 32'h0000_0000);
    @(posedge clock_i);
    enc   <= $random(seed);
    motor <= $random(seed);
    traj  <= $random(seed);
    pos   <= $random(seed);
    host.bus_wr(`SVTO_A_MODE, {29'h0, `SVTO_MODE_PV});
    wait_n(2);
    rd_chk(`SVTO_A_ENC_SPEED, enc);
    rd_chk(`SVTO_A_MOT_SPEED, motor);
    rd_chk(`SVTO_A_SPD_DEMAND, traj);
    host.bus_wr(`SVTO_A_MODE, {29'h0, `SVTO_MODE_CSP});
    wait_n(2);
    rd_chk(`SVTO_A_SPD_DEMAND, pos);
    for (i = 0; i < 24; i++) begin
      md  = {1'b0, i[1:0]} + 3'h1;
      tgt = (i == 3) ? 16'h8000 : $random(seed);
      ofs = (i == 3) ? 16'h8000 : $random(seed);
      cl  = {4'h0, 12'($random(seed))};
      fw  = (i < 4) ? 16'hFFFF : {4'h0, 12'($random(seed))};
      rv  = {4'h0, 12'($random(seed))};
      ff  = $random(seed);
      cmd = $random(seed);
      motor <= $random(seed);
      host.bus_wr(`SVTO_A_MODE, {29'h0, md});
      host.bus_wr(`SVTO_A_TRQ_CMD, {16'h0, tgt});
      host.bus_wr(`SVTO_A_TRQ_FF, {16'h0, ofs});
      host.bus_wr(`SVTO_A_TRQ_CEIL, {16'h0, cl});
      host.bus_wr(`SVTO_A_FWD_LIMIT, {16'h0, fw});
      host.bus_wr(`SVTO_A_REV_LIMIT, {16'h0, rv});
      host.bus_wr(`SVTO_A_SPD_FF, ff);
      host.bus_wr(`SVTO_A_SPD_CMD, cmd);
      wait_n(3);
      sum = {{2{tgt[15]}}, tgt} + ((md == `SVTO_MODE_CST) ? {{2{ofs[15]}}, ofs} : 18'h0_0000);
      ex  = svto_sat(sum, cl, fw, rv);
      check({16'h0, torque_ref}, {16'h0, ex});
      check({16'h0, torque_ff}, (md == `SVTO_MODE_CSP || md == `SVTO_MODE_CSV) ? ofs : 0);
      check(speed_ref, (md == `SVTO_MODE_CSP) ? ff : (md == `SVTO_MODE_CST) ? 0 : cmd);
      rd_chk(`SVTO_A_TRQ_READING, {16'h0, ex});
    end
    host.bus_wr(`SVTO_A_FWD_LIMIT, 32'h0000_FFFF);
    host.bus_wr(`SVTO_A_TRQ_CEIL, 32'h0000_0BB8);
    host.bus_wr(`SVTO_A_RAMP_RATE, 32'h00FF_FFFF);
    host.bus_wr(`SVTO_A_TRQ_FF, 32'h0000_8000);
    host.bus_wr(`SVTO_A_TRQ_CMD, 32'h0000_1388);
    host.bus_wr(`SVTO_A_MODE, {29'h0, `SVTO_MODE_PT});
    k = 0;
    while (torque_ref !== 16'h0BB8 && k < 50000) begin
      @(posedge clock_i);
      k = k + 1;
    end
    check({16'h0, torque_ref}, 32'h0000_0BB8);
    @(posedge clock_i);
    motor <= 32'h0000_03FC;
    host.bus_wr(`SVTO_A_COIN_WIDTH, 32'h0000_000A);
    host.bus_wr(`SVTO_A_SPD_CMD, 32'h0000_03E8);
    host.bus_wr(`SVTO_A_THR_LEVEL, 32'h0000_7530);
    host.bus_wr(`SVTO_A_IRQ_ENABLE, 32'h0000_0000);
    host.bus_wr(`SVTO_A_IRQ_CLEAR, 32'h0000_0003);
    motor <= 32'h0000_03ED;
    wait_n(8);
    check(status_word[10], 1'b1);
    check(status_word[12], 1'b0);
    check(irq, 1'b0);
    rd_chk(`SVTO_A_IRQ_STATUS, 32'h0000_0001);
    host.bus_wr(`SVTO_A_IRQ_ENABLE, 32'h0000_0001);
    wait_n(2);
    check(irq, 1'b1);
    host.bus_wr(`SVTO_A_IRQ_CLEAR, 32'h0000_0001);
    wait_n(2);
    check(irq, 1'b0);
    motor <= 32'h0000_03FC;
    wait_n(8);
    check(status_word[10], 1'b0);
    host.bus_wr(`SVTO_A_THR_LEVEL, 32'h0000_03E8);
    wait_n(8);
    check(status_word[12], 1'b1);
    check(irq, 1'b0);
    rd_chk(`SVTO_A_IRQ_STATUS, 32'h0000_0002);
    host.bus_wr(`SVTO_A_IRQ_ENABLE, 32'h0000_0003);
    wait_n(2);
    check(irq, 1'b1);
    motor <= 32'h0000_03E8;
    wait_n(8);
    check(status_word[12], 1'b0);
    check(status_word[10], 1'b1);
    wrap_up();
  end
endmodule
`default_nettype wire
